// file: include/scb_pkg.sv
// system control bank constants: register offset, field positions, reset values.
// assumes a configuration access port that presents byte offsets and byte enables.
package scb_pkg;

  // ----------------------------------------------------------------
  // register placement
  // ----------------------------------------------------------------
  localparam logic [7:0]  SYS_CTRL_OFS   = 8'h80;
  localparam logic [31:0] SYS_CTRL_RST   = 32'h0044_9060;
  // lower half belongs to other logic; it reads back its reset image here
  localparam logic [15:0] LOWER_HALF_IMG = 16'h9060;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int STEP_LO   = 30;
  localparam int TIE_BIT   = 29;
  localparam int RSVD_BIT  = 28;
  localparam int CLKSRC    = 27;
  localparam int ROUTE_BIT = 26;
  localparam int FLAG_BIT  = 25;
  localparam int SMIEN_BIT = 24;
  localparam int PMREV_BIT = 23;
  localparam int RSVDRV    = 22;
  localparam int VPROT_BIT = 21;
  localparam int RZV_BIT   = 20;
  localparam int DREQEN    = 19;
  localparam int CHAN_LO   = 16;

  // byte lanes holding the fields above
  localparam int LANE_HI   = 3;
  localparam int LANE_MID  = 2;

  // ----------------------------------------------------------------
  // field reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] STEP_RST   = 2'h0;
  localparam logic       TIE_RST    = 1'h0;
  localparam logic       CLKSRC_RST = 1'h0;
  localparam logic       ROUTE_RST  = 1'h0;
  localparam logic       SMIEN_RST  = 1'h0;
  localparam logic       PMREV_RST  = 1'h0;
  localparam logic       RSVDRV_RST = 1'h1;
  localparam logic       VPROT_RST  = 1'h0;
  localparam logic       RZV_RST    = 1'h0;
  localparam logic       DREQEN_RST = 1'h0;
  localparam logic [2:0] CHAN_RST   = 3'h4;

  // channel code meaning pci master, never a card channel
  localparam logic [2:0] CHAN_PCI_MASTER = 3'h4;

  // function that owns the global fields
  localparam logic GLOBAL_FUNC = 1'h0;

endpackage : scb_pkg

// file: include/scb_sock_if.sv
// per-socket settings and card pin results between the bank and a socket pin block.
// assumes one instance per socket, all on the same clock.
interface scb_sock_if;
  logic       rsvd_drive;
  logic       reduced_video;
  logic       dreq_enable;
  logic [2:0] dma_channel;
  logic       rsvd_oe;
  logic       addr_hi_float;
  logic       pcpci_dreq;

  modport ctl  (output rsvd_drive, reduced_video, dreq_enable, dma_channel,
                input  rsvd_oe, addr_hi_float, pcpci_dreq);
  modport pins (input  rsvd_drive, reduced_video, dreq_enable, dma_channel,
                output rsvd_oe, addr_hi_float, pcpci_dreq);
endinterface : scb_sock_if

// file: src/scb_irq_steer.sv
// steering of the two pci interrupt requests into the four serial interrupt slots.
// assumes requests are levels synchronous to clk.
module scb_irq_steer (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [1:0] step,
  input  wire logic       tie,
  input  wire logic       req_a,
  input  wire logic       req_b,
  output logic [3:0]      slots_r
);

  // rotate the a/b pair up by the step count, wrapping d back to a
  function automatic logic [3:0] scb_rotate(input logic [3:0] v, input logic [1:0] s);
    logic [7:0] d;
    d = {v, v} << s;
    return d[7:4];
  endfunction : scb_rotate

  logic       a_eff;
  logic       b_eff;
  logic [3:0] slots_nxt;

  assign a_eff     = tie ? (req_a | req_b) : req_a;
  assign b_eff     = tie ? 1'b0 : req_b;
  assign slots_nxt = scb_rotate({2'b00, b_eff, a_eff}, step);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) slots_r <= 4'h0;
    else         slots_r <= slots_nxt;
  end

endmodule : scb_irq_steer

// file: src/scb_sock_pins.sv
// card-side pin control of one socket: reserved terminals, high address float, dma request.
// assumes card presence and request inputs are synchronous to clk.
module scb_sock_pins (
  input  wire logic  clk,
  input  wire logic  resetn,
  input  wire logic  cb_present,
  input  wire logic  card16_present,
  input  wire logic  card_dreq,
  scb_sock_if.pins   sk
);

  logic dreq_ok;

  // a request on the pci-master code has no channel to go to, so it is dropped
  assign dreq_ok = sk.dreq_enable & card16_present & card_dreq
                   & (sk.dma_channel != scb_pkg::CHAN_PCI_MASTER);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sk.rsvd_oe       <= 1'b0;
      sk.addr_hi_float <= 1'b0;
      sk.pcpci_dreq    <= 1'b0;
    end else begin
      sk.rsvd_oe       <= cb_present & sk.rsvd_drive;
      sk.addr_hi_float <= card16_present & sk.reduced_video;
      sk.pcpci_dreq    <= dreq_ok;
    end
  end

endmodule : scb_sock_pins

// file: src/scb_top.sv
// system control register bank of a two-socket card bridge, upper half of the word.
// assumes configuration cycles arrive as single-cycle strobes synchronous to clk,
// with function number selecting the socket.

// Notes on behaviour
// - Interrupt pair lands in slots A/B, B/C, C/D or D/A by the step field.
// - Tie merges both requests onto A, which the step field still shifts.
// - Global fields except routing are written only through function 0; routing through either; both functions read them.
// - Bit 28 always reads zero.
// - Clock source bit: 0 takes pin as input, 1 drives internal oscillator out.
// - Selected clock times the switch serial interface and power state machine.
// - Routing bit picks legacy irq two or card status change on power writes.
// - Per-socket flag sets when enable is on and that socket's power is written.
// - Writing one clears the flag; writing zero leaves it.
// - Enable bit makes power writes raise the management interrupt; resets off.
// - Revision bit selects power management revision 1.0 or 1.1 behaviour.
// - Reserved card terminals driven low when drive bit set and a CardBus card is present, else floated.
// - Per-socket supply protection for 16-bit cards, on unless bit set.
// - Reduced video bit floats card address A25-A22 for 16-bit cards.
// - Request enable forwards 16-bit card dma requests on any channel but 4; otherwise they are ignored.
// - Channel field: 0-3 eight-bit, 4 pci master unused, 5-7 sixteen-bit.
// - Register decodes at 80h in both functions with its reset value.
module scb_top #(
  parameter int SOCKETS = 2
) (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // configuration access
  input  wire logic                 cfg_func,
  input  wire logic [7:0]           cfg_addr,
  input  wire logic [3:0]           cfg_be,
  input  wire logic                 cfg_wr,
  input  wire logic                 cfg_rd,
  input  wire logic [31:0]          cfg_wdata,
  output logic      [31:0]          cfg_rdata,
  output logic                      cfg_rvalid,
  // interrupt slots
  input  wire logic                 int_a_req,
  input  wire logic                 int_b_req,
  output logic      [3:0]           irq_slot,
  // power switch clock pin
  input  wire logic                 switch_clk_in,
  input  wire logic                 osc_clk_in,
  output logic                      switch_clk_out,
  output logic                      switch_clk_oe,
  output logic                      switch_tick,
  // socket power writes
  input  wire logic                 sock_power_wr,
  input  wire logic                 sock_power_sel,
  output logic                      sysmgmt_irq,
  output logic                      legacy_irq_two,
  output logic      [SOCKETS-1:0]   card_status_change_irq,
  // per-socket modes
  output logic      [SOCKETS-1:0]   pm_revision,
  output logic      [SOCKETS-1:0]   supply_protect_en,
  // card pins
  input  wire logic [SOCKETS-1:0]   cb_present,
  input  wire logic [SOCKETS-1:0]   card16_present,
  input  wire logic [SOCKETS-1:0]   card_dreq,
  output logic      [SOCKETS-1:0]   card_rsvd_out,
  output logic      [SOCKETS-1:0]   card_rsvd_oe,
  output logic      [SOCKETS-1:0]   card_addr_hi_float,
  output logic      [SOCKETS-1:0]   pcpci_dreq,
  output logic      [3*SOCKETS-1:0] pcpci_dma_chan
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  // the function number is one bit and picks the socket, so two is the only fit
  if (SOCKETS != 2) begin : g_bad_sockets
    $error("scb_top: SOCKETS must be 2");
  end

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  logic       hit;
  logic       wr_hit;
  logic       rd_hit;
  logic       wr_hi;
  logic       wr_mid;
  logic       wr_global_hi;

  assign hit           = (cfg_addr == scb_pkg::SYS_CTRL_OFS);
  assign wr_hit        = cfg_wr & hit;
  assign rd_hit        = cfg_rd & hit;
  assign wr_hi         = wr_hit & cfg_be[scb_pkg::LANE_HI];
  assign wr_mid        = wr_hit & cfg_be[scb_pkg::LANE_MID];
  assign wr_global_hi  = wr_hi & (cfg_func == scb_pkg::GLOBAL_FUNC);
  // lane two holds socket fields only, so its writes need no function-0 guard

  // ----------------------------------------------------------------
  // global fields, held once
  // ----------------------------------------------------------------
  logic [1:0] step_r;
  logic       tie_r;
  logic       clksrc_r;
  logic       smien_r;
  logic       route_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      step_r   <= scb_pkg::STEP_RST;
      tie_r    <= scb_pkg::TIE_RST;
      clksrc_r <= scb_pkg::CLKSRC_RST;
      smien_r  <= scb_pkg::SMIEN_RST;
    end else if (wr_global_hi) begin
      step_r   <= cfg_wdata[scb_pkg::STEP_LO +: 2];
      tie_r    <= cfg_wdata[scb_pkg::TIE_BIT];
      clksrc_r <= cfg_wdata[scb_pkg::CLKSRC];
      smien_r  <= cfg_wdata[scb_pkg::SMIEN_BIT];
    end
  end

  // routing is shared but either function may write it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)    route_r <= scb_pkg::ROUTE_RST;
    else if (wr_hi) route_r <= cfg_wdata[scb_pkg::ROUTE_BIT];
  end

  // ----------------------------------------------------------------
  // socket fields, one copy per function
  // ----------------------------------------------------------------
  logic [SOCKETS-1:0] flag_r;
  logic [SOCKETS-1:0] pmrev_r;
  logic [SOCKETS-1:0] rsvdrv_r;
  logic [SOCKETS-1:0] vprot_r;
  logic [SOCKETS-1:0] rzv_r;
  logic [SOCKETS-1:0] dreqen_r;
  logic [2:0]         chan_r [SOCKETS];
  logic [SOCKETS-1:0] rsvd_oe_w;
  logic [SOCKETS-1:0] addr_float_w;
  logic [SOCKETS-1:0] dreq_w;

  for (genvar s = 0; s < SOCKETS; s++) begin : g_sock
    logic       own_mid;
    logic       flag_set;
    logic       flag_clr;
    logic       flag_nxt;

    assign own_mid  = wr_mid & (cfg_func == s[0]);
    assign flag_set = sock_power_wr & smien_r & (sock_power_sel == s[0]);
    assign flag_clr = wr_hi & (cfg_func == s[0]) & cfg_wdata[scb_pkg::FLAG_BIT];
    // a power write landing with the clear keeps the flag set
    assign flag_nxt = flag_set | (flag_r[s] & ~flag_clr);

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) flag_r[s] <= 1'b0;
      else         flag_r[s] <= flag_nxt;
    end

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        pmrev_r[s]  <= scb_pkg::PMREV_RST;
        rsvdrv_r[s] <= scb_pkg::RSVDRV_RST;
        vprot_r[s]  <= scb_pkg::VPROT_RST;
        rzv_r[s]    <= scb_pkg::RZV_RST;
        dreqen_r[s] <= scb_pkg::DREQEN_RST;
        chan_r[s]   <= scb_pkg::CHAN_RST;
      end else if (own_mid) begin
        pmrev_r[s]  <= cfg_wdata[scb_pkg::PMREV_BIT];
        rsvdrv_r[s] <= cfg_wdata[scb_pkg::RSVDRV];
        vprot_r[s]  <= cfg_wdata[scb_pkg::VPROT_BIT];
        rzv_r[s]    <= cfg_wdata[scb_pkg::RZV_BIT];
        dreqen_r[s] <= cfg_wdata[scb_pkg::DREQEN];
        chan_r[s]   <= cfg_wdata[scb_pkg::CHAN_LO +: 3];
      end
    end

    scb_sock_if sk ();

    assign sk.rsvd_drive    = rsvdrv_r[s];
    assign sk.reduced_video = rzv_r[s];
    assign sk.dreq_enable   = dreqen_r[s];
    assign sk.dma_channel   = chan_r[s];
    assign rsvd_oe_w[s]     = sk.rsvd_oe;
    assign addr_float_w[s]  = sk.addr_hi_float;
    assign dreq_w[s]        = sk.pcpci_dreq;

    scb_sock_pins u_pins (
      .clk            (clk),
      .resetn         (resetn),
      .cb_present     (cb_present[s]),
      .card16_present (card16_present[s]),
      .card_dreq      (card_dreq[s]),
      .sk             (sk)
    );

    assign pcpci_dma_chan[3*s +: 3] = chan_r[s];
  end

  assign pm_revision            = pmrev_r;
  assign card_rsvd_oe           = rsvd_oe_w;
  assign card_addr_hi_float     = addr_float_w;
  assign pcpci_dreq             = dreq_w;

  // ----------------------------------------------------------------
  // supply protection and reserved terminal level
  // ----------------------------------------------------------------
  logic [SOCKETS-1:0] prot_en_r;
  logic [SOCKETS-1:0] rsvd_lvl_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prot_en_r  <= {SOCKETS{1'b1}};
      rsvd_lvl_r <= {SOCKETS{1'b0}};
    end else begin
      prot_en_r  <= ~vprot_r;
      rsvd_lvl_r <= {SOCKETS{1'b0}};
    end
  end

  assign supply_protect_en = prot_en_r;
  assign card_rsvd_out     = rsvd_lvl_r;

  // ----------------------------------------------------------------
  // interrupt slot steering
  // ----------------------------------------------------------------
  // tie is trusted to be set only after the serial irq pin is configured
  scb_irq_steer u_steer (
    .clk     (clk),
    .resetn  (resetn),
    .step    (step_r),
    .tie     (tie_r),
    .req_a   (int_a_req),
    .req_b   (int_b_req),
    .slots_r (irq_slot)
  );

  // ----------------------------------------------------------------
  // power switch clock source
  // ----------------------------------------------------------------
  logic sel_clk;
  logic sel_clk_r;
  logic clk_out_r;
  logic clk_oe_r;
  logic tick_r;

  assign sel_clk = clksrc_r ? osc_clk_in : switch_clk_in;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clk_out_r <= 1'b0;
      clk_oe_r  <= 1'b0;
    end else begin
      clk_out_r <= osc_clk_in;
      clk_oe_r  <= clksrc_r;
    end
  end

  // the tick paces both the switch serial link and the power state machine;
  // sampling limits the usable switch clock to well below half of clk
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_clk_r <= 1'b0;
      tick_r    <= 1'b0;
    end else begin
      sel_clk_r <= sel_clk;
      tick_r    <= sel_clk & ~sel_clk_r;
    end
  end

  assign switch_clk_out = clk_out_r;
  assign switch_clk_oe  = clk_oe_r;
  assign switch_tick    = tick_r;

  // ----------------------------------------------------------------
  // power write signalling
  // ----------------------------------------------------------------
  logic               smi_fire;
  logic               smi_r;
  logic               legacy_irq_two_r;
  logic [SOCKETS-1:0] csc_r;
  logic [SOCKETS-1:0] csc_nxt;

  assign smi_fire = sock_power_wr & smien_r;
  assign csc_nxt  = (smi_fire & route_r) ? (SOCKETS'(1) << sock_power_sel)
                                         : {SOCKETS{1'b0}};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      smi_r  <= 1'b0;
      legacy_irq_two_r <= 1'b0;
      csc_r  <= {SOCKETS{1'b0}};
    end else begin
      smi_r  <= smi_fire;
      legacy_irq_two_r <= smi_fire & ~route_r;
      csc_r  <= csc_nxt;
    end
  end

  assign sysmgmt_irq            = smi_r;
  assign legacy_irq_two         = legacy_irq_two_r;
  assign card_status_change_irq = csc_r;

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  logic [31:0] word;
  logic [31:0] rdata_nxt;
  logic [31:0] rdata_r;
  logic        rvalid_r;

  always_comb begin
    word                                 = 32'h0000_0000;
    word[15:0]                           = scb_pkg::LOWER_HALF_IMG;
    word[scb_pkg::STEP_LO +: 2]          = step_r;
    word[scb_pkg::TIE_BIT]               = tie_r;
    word[scb_pkg::CLKSRC]                = clksrc_r;
    word[scb_pkg::ROUTE_BIT]             = route_r;
    word[scb_pkg::FLAG_BIT]              = flag_r[cfg_func];
    word[scb_pkg::SMIEN_BIT]             = smien_r;
    word[scb_pkg::PMREV_BIT]             = pmrev_r[cfg_func];
    word[scb_pkg::RSVDRV]                = rsvdrv_r[cfg_func];
    word[scb_pkg::VPROT_BIT]             = vprot_r[cfg_func];
    word[scb_pkg::RZV_BIT]               = rzv_r[cfg_func];
    word[scb_pkg::DREQEN]                = dreqen_r[cfg_func];
    word[scb_pkg::CHAN_LO +: 3]          = chan_r[cfg_func];
  end

  // unmapped offsets answer with zero so a probe never hangs
  assign rdata_nxt = rd_hit ? word : 32'h0000_0000;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r  <= 32'h0000_0000;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= cfg_rd;
    end
  end

  assign cfg_rdata  = rdata_r;
  assign cfg_rvalid = rvalid_r;

endmodule : scb_top

// file: testbench/scb_host_model.sv
// host model issuing configuration writes and reads.
// assumes one-cycle strobes and a read answer one cycle later.
module scb_host_model (
  input  wire logic        clk,
  output logic             cfg_func,
  output logic [7:0]       cfg_addr,
  output logic [3:0]       cfg_be,
  output logic             cfg_wr,
  output logic             cfg_rd,
  output logic [31:0]      cfg_wdata,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {cfg_func, cfg_addr, cfg_be, cfg_wr, cfg_rd, cfg_wdata} = '0;
  end
  task automatic wr(input logic f, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    cfg_func  <= f;
    cfg_addr  <= a;
    cfg_be    <= be;
    cfg_wdata <= d;
    cfg_wr    <= 1'b1;
    @(posedge clk);
    cfg_wr    <= 1'b0;
    // released data must not look like a held value
    cfg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic f, input logic [7:0] a, output logic [31:0] d, output logic ok);
    ok = 1'b0;
    d = '0;
    @(posedge clk);
    cfg_func <= f;
    cfg_addr <= a;
    cfg_rd   <= 1'b1;
    @(posedge clk);
    cfg_rd   <= 1'b0;
    for (int i = 0; i < 3 && !ok; i++) begin
      #1;
      if (cfg_rvalid === 1'b1) begin
        d = cfg_rdata;
        ok = 1'b1;
      end else @(posedge clk);
    end
  endtask : rd
endmodule : scb_host_model

// file: testbench/scb_top_properties.sv
// checker for the system control bank, watching top ports only.
// assumes it is bound into scb_top, ports connected by name.
module scb_top_checker #(
  parameter int SOCKETS = 2
) (
  input wire logic               clk,
  input wire logic               resetn,
  input wire logic [7:0]         cfg_addr,
  input wire logic               cfg_rd,
  input wire logic               cfg_rvalid,
  input wire logic [31:0]        cfg_rdata,
  input wire logic               int_a_req,
  input wire logic               int_b_req,
  input wire logic [3:0]         irq_slot,
  input wire logic               switch_clk_oe,
  input wire logic               switch_tick,
  input wire logic               sock_power_wr,
  input wire logic               sysmgmt_irq,
  input wire logic               legacy_irq_two,
  input wire logic [SOCKETS-1:0] card_status_change_irq,
  input wire logic [SOCKETS-1:0] cb_present,
  input wire logic [SOCKETS-1:0] card_rsvd_out,
  input wire logic [SOCKETS-1:0] card_rsvd_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_ans; cfg_rd |=> cfg_rvalid; endproperty
  a_ans: assert property (p_ans) else $error("read not answered");
  // unmapped offsets answer zero, so the field checks look only at reads of the bank
  property p_fix; cfg_rvalid && $past(cfg_addr) == 8'h80 |-> !cfg_rdata[28] && cfg_rdata[15:0] == 16'h9060;
  endproperty
  a_fix: assert property (p_fix) else $error("fixed bits wrong");
  property p_oe; cfg_rvalid && $past(cfg_addr) == 8'h80 |-> cfg_rdata[27] == switch_clk_oe; endproperty
  a_oe: assert property (p_oe) else $error("clock pin drive wrong");
  property p_unm; cfg_rvalid && $past(cfg_addr) != 8'h80 |-> cfg_rdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_smi; sysmgmt_irq |-> $past(sock_power_wr); endproperty
  a_smi: assert property (p_smi) else $error("stray management irq");
  property p_rt; legacy_irq_two || card_status_change_irq != '0 |-> sysmgmt_irq
    && !(legacy_irq_two && card_status_change_irq != '0); endproperty
  a_rt: assert property (p_rt) else $error("irq route wrong");
  property p_tick; switch_tick |=> !switch_tick; endproperty
  a_tick: assert property (p_tick) else $error("tick too long");
  property p_slot; irq_slot != 4'h0 |-> $past(int_a_req || int_b_req); endproperty
  a_slot: assert property (p_slot) else $error("slot without request");
  property p_rsv; card_rsvd_oe[0] |-> $past(cb_present[0]) && card_rsvd_out == '0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved pin drive wrong");
  c_rd: cover property (cfg_rvalid);
  c_smi: cover property (sysmgmt_irq);
  c_tick: cover property (switch_tick);
endmodule : scb_top_checker
bind scb_top scb_top_checker #(.SOCKETS(SOCKETS)) u_chk (.*);

// file: testbench/scb_top_tb.sv
// self-checking bench for the system control bank.
// assumes the host model drives all configuration cycles.
module scb_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, resetn, cfg_func, cfg_wr, cfg_rd, cfg_rvalid, int_a_req, int_b_req;
  logic        switch_clk_in, osc_clk_in, switch_clk_out, switch_clk_oe, switch_tick;
  logic        sock_power_wr, sock_power_sel, sysmgmt_irq, legacy_irq_two;
  logic [1:0]  card_status_change_irq, pm_revision, supply_protect_en, cb_present;
  logic [1:0]  card16_present, card_dreq, card_rsvd_out, card_rsvd_oe, card_addr_hi_float, pcpci_dreq;
  logic [3:0]  cfg_be, irq_slot;
  logic [5:0]  pcpci_dma_chan;
  logic [7:0]  cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [2:0]  div_r = 3'h0;
  int          num_errors = 0;
  int          checks = 0;
  scb_top #(.SOCKETS(2)) DUT (.*);
  scb_host_model host (.*);
  initial clk = 1'b0;
  always #5 clk = ~clk;
  // slow oscillator and pin levels so the tick logic sees edges
  always @(posedge clk) begin
    div_r         <= div_r + 3'h1;
    osc_clk_in    <= div_r[0];
    switch_clk_in <= div_r[2];
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  task automatic rdchk(input logic f, input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic        ok;
    host.rd(f, a, d, ok);
    if (!ok) begin
      num_errors++;
      close_out();
    end else begin
      chk(what, d, exp);
    end
  endtask : rdchk
  // oscillator copy on the pin, and ticks of the selected source over eight cycles
  task automatic t_clock(input logic src);
    logic [31:0] n;
    logic        o;
    n = 32'h0;
    o = osc_clk_in;
    @(posedge clk);
    #1;
    chk("clk out", 32'(switch_clk_out), 32'(o));
    chk("clk oe", 32'(switch_clk_oe), 32'(src));
    repeat (8) begin
      n = n + 32'(switch_tick);
      @(posedge clk);
      #1;
    end
    chk("ticks", n, src ? 32'h4 : 32'h1);
  endtask : t_clock
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  task automatic pw(input logic s);
    @(posedge clk);
    sock_power_wr  <= 1'b1;
    sock_power_sel <= s;
    @(posedge clk);
    sock_power_wr  <= 1'b0;
    #1;
  endtask : pw
  task automatic t_reset();
    rdchk(1'b0, 8'h80, 32'h0044_9060, "reset f0");
    rdchk(1'b1, 8'h80, 32'h0044_9060, "reset f1");
    rdchk(1'b0, 8'h84, 32'h0, "unmapped");
    chk("protect", 32'(supply_protect_en), 32'h3);
  endtask : t_reset
  task automatic t_global();
    host.wr(1'b1, 8'h80, 4'hF, 32'hFFFF_FFFF);
    rdchk(1'b0, 8'h80, 32'h0444_9060, "f1 write");
    host.wr(1'b0, 8'h80, 4'hF, 32'hFFFF_FFFF);
    rdchk(1'b0, 8'h80, 32'hEDFF_9060, "ones f0");
    rdchk(1'b1, 8'h80, 32'hEDFF_9060, "ones f1");
    chk("clk oe", 32'(switch_clk_oe), 32'h1);
    chk("pm rev", 32'(pm_revision), 32'h3);
    chk("chan", 32'(pcpci_dma_chan), 32'h3F);
    t_clock(1'b1);
    host.wr(1'b1, 8'h80, 4'h4, 32'h0);
    settle();
    chk("protect", 32'(supply_protect_en), 32'h2);
    chk("pm rev", 32'(pm_revision), 32'h1);
  endtask : t_global
  task automatic t_slots();
    for (int s = 0; s < 4; s++) begin
      for (int t = 0; t < 2; t++) begin
        // pin three taken as already in serial irq mode before tie
        host.wr(1'b0, 8'h80, 4'h8, {s[1:0], t[0], 29'h0});
        int_a_req <= 1'b1;
        int_b_req <= 1'b0;
        settle();
        chk("slot a", 32'(irq_slot), 32'(4'h1 << s));
        int_a_req <= 1'b0;
        int_b_req <= 1'b1;
        settle();
        chk("slot b", 32'(irq_slot), 32'(4'h1 << ((s + 1 - t) % 4)));
      end
    end
    int_b_req <= 1'b0;
    t_clock(1'b0);
  endtask : t_slots
  task automatic t_smi();
    host.wr(1'b0, 8'h80, 4'h8, 32'h0100_0000);
    pw(1'b1);
    chk("smi", 32'(sysmgmt_irq), 32'h1);
    chk("legacy_irq_two", 32'(legacy_irq_two), 32'h1);
    chk("csc", 32'(card_status_change_irq), 32'h0);
    rdchk(1'b1, 8'h80, 32'h0300_9060, "flag set");
    rdchk(1'b0, 8'h80, 32'h01FF_9060, "flag other");
    host.wr(1'b1, 8'h80, 4'h8, 32'h0);
    rdchk(1'b1, 8'h80, 32'h0300_9060, "flag kept");
    host.wr(1'b1, 8'h80, 4'h8, 32'h0200_0000);
    rdchk(1'b1, 8'h80, 32'h0100_9060, "flag clear");
    host.wr(1'b0, 8'h80, 4'h8, 32'h0500_0000);
    pw(1'b0);
    chk("csc", 32'(card_status_change_irq), 32'h1);
    chk("legacy_irq_two", 32'(legacy_irq_two), 32'h0);
    host.wr(1'b0, 8'h80, 4'h8, 32'h0);
    pw(1'b0);
    chk("smi off", 32'(sysmgmt_irq), 32'h0);
  endtask : t_smi
  task automatic t_pins();
    host.wr(1'b0, 8'h80, 4'h4, 32'h005D_0000);
    cb_present     <= 2'h3;
    card16_present <= 2'h3;
    card_dreq      <= 2'h3;
    settle();
    chk("rsvd oe", 32'(card_rsvd_oe), 32'h1);
    chk("rsvd out", 32'(card_rsvd_out), 32'h0);
    chk("float", 32'(card_addr_hi_float), 32'h1);
    chk("dreq", 32'(pcpci_dreq), 32'h1);
    chk("chan", 32'(pcpci_dma_chan[2:0]), 32'h5);
    host.wr(1'b0, 8'h80, 4'h4, 32'h005C_0000);
    settle();
    chk("dreq ch4", 32'(pcpci_dreq), 32'h0);
    host.wr(1'b0, 8'h80, 4'h4, 32'h0015_0000);
    settle();
    chk("dreq off", 32'(pcpci_dreq), 32'h0);
    chk("rsvd off", 32'(card_rsvd_oe), 32'h0);
  endtask : t_pins
  initial begin
    resetn = 1'b0;
    {int_a_req, int_b_req, sock_power_wr, sock_power_sel} = '0;
    {cb_present, card16_present, card_dreq} = '0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_global();
    t_slots();
    t_smi();
    t_pins();
    close_out();
  end
endmodule : scb_top_tb
